//--- asf_pkg.sv
// constants, types and register map of the sample buffer
package asf_pkg;

    // ******************************************
    // sizes
    // ******************************************
    localparam int ASF_DEPTH = 256;
    localparam int ASF_SW = 14;
    localparam int ASF_CW = 9;
    localparam logic [8:0] ASF_FULL = 9'h100;

    // ******************************************
    // register offsets
    // ******************************************
    localparam logic [7:0] OFS_MAG_HIGH = 8'h0c;
    localparam logic [7:0] OFS_IF_CTRL = 8'h21;
    localparam logic [7:0] OFS_IRQ_A = 8'h23;
    localparam logic [7:0] OFS_IRQ_B = 8'h24;
    localparam logic [7:0] OFS_BUF_CTRL = 8'h25;
    localparam logic [7:0] OFS_OUT_FIRST = 8'h28;
    localparam logic [7:0] OFS_OUT_LAST = 8'h2d;
    localparam logic [7:0] OFS_THRESH = 8'h2e;
    localparam logic [7:0] OFS_SRC = 8'h2f;
    localparam logic [7:0] OFS_COUNT = 8'h30;
    localparam logic [7:0] OFS_EMBEDDED_FUNCTION_CONTROL = 8'h3f;

    // ******************************************
    // field positions
    // ******************************************
    localparam int BIT_ADDR_INC = 2;
    localparam int BIT_THRESH_ROUTE = 1;
    localparam int BIT_OVR_ROUTE = 3;
    localparam int BIT_MAG_CAPTURE = 3;
    localparam int POS_MODE = 5;
    localparam int BIT_MAG_ROUTINE = 5;
    localparam int BIT_SRC_THRESH = 7;
    localparam int BIT_SRC_OVR = 6;
    localparam int BIT_SRC_EMPTY = 5;

    // ******************************************
    // reset values
    // ******************************************
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [8:0] RST_COUNT = 9'h000;

    // ******************************************
    // types
    // ******************************************
    typedef enum logic [2:0] {
        MODE_BYPASS = 3'b000,
        MODE_STOP_FULL = 3'b001,
        MODE_CONT_TO_STOP = 3'b011,
        MODE_BYP_TO_CONT = 3'b100,
        MODE_CONT = 3'b110
    } asf_mode_t;

    typedef struct packed {
        logic [13:0] x;
        logic [13:0] y;
        logic [13:0] z;
    } asf_sample_t;

endpackage

//--- asf_magnitude.sv
// vector magnitude approximation of one x/y/z sample
`timescale 1ns/1ps
`default_nettype none

module asf_magnitude
    import asf_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // sample in
    input wire logic in_valid,
    input wire asf_sample_t in_sample,
    // magnitude out
    output logic mag_valid,
    output logic [13:0] mag_r
);

    // ******************************************
    // helpers
    // ******************************************
    function automatic logic [13:0] abs14(input logic [13:0] v);
        abs14 = v[13] ? 14'(~v + 14'h0001) : v;
    endfunction

    logic [13:0] ax, ay, az, hi, md, lo;
    logic [15:0] sum;

    // sqrt(x2+y2+z2) ~ max + 5/16 * (mid + min)
    always_comb begin
        ax = abs14(in_sample.x);
        ay = abs14(in_sample.y);
        az = abs14(in_sample.z);
        hi = ax;
        md = ay;
        lo = az;
        if (ay > hi) begin
            hi = ay;
            md = ax;
        end
        if (az > hi) begin
            lo = md;
            md = hi;
            hi = az;
        end else if (az > md) begin
            lo = md;
            md = az;
        end
        sum = {2'b00, hi} + 16'((({4'h0, md} + {4'h0, lo}) * 18'd5) >> 4);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mag_valid <= 1'b0;
            mag_r <= 14'h0000;
        end else begin
            mag_valid <= in_valid;
            if (in_valid) begin
                mag_r <= (sum > 16'h3fff) ? 14'h3fff : sum[13:0];
            end
        end
    end

endmodule

`default_nettype wire

//--- asf_buffer.sv
// sample buffer with modes, threshold, overrun and register port
`timescale 1ns/1ps
`default_nettype none

module asf_buffer
    import asf_pkg::*;
#(
    parameter int DEPTH = ASF_DEPTH
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // conversion results
    input wire logic sample_valid,
    input wire asf_sample_t sample_in,
    // event recognition trigger
    input wire logic trigger_evt,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_burst,
    output logic [7:0] reg_rdata,
    // interrupt pins
    output logic irq_pin_a,
    output logic irq_pin_b
);

    // ******************************************
    // helpers
    // ******************************************
    function automatic logic [7:0] lane(input logic [13:0] v,
                                        input logic hi);
        lane = hi ? v[13:6] : {v[5:0], 2'b00};
    endfunction

    function automatic logic [7:0] out_byte(input asf_sample_t s,
                                            input logic [2:0] idx);
        case (idx)
            3'd0: out_byte = lane(s.x, 1'b0);
            3'd1: out_byte = lane(s.x, 1'b1);
            3'd2: out_byte = lane(s.y, 1'b0);
            3'd3: out_byte = lane(s.y, 1'b1);
            3'd4: out_byte = lane(s.z, 1'b0);
            default: out_byte = lane(s.z, 1'b1);
        endcase
    endfunction

    // ******************************************
    // registers
    // ******************************************
    logic [7:0] if_ctrl_r, irq_a_r, irq_b_r, buf_ctrl_r, thresh_r;
    logic [7:0] embedded_function_control_r, mag_high_r, last_addr_r;
    logic [8:0] count_r;
    logic [7:0] wr_ptr_r, rd_ptr_r;
    logic overrun_r, trig_seen_r;
    asf_sample_t latest_r;
    asf_sample_t store [DEPTH];
    logic [1:0] mag_idx_r;
    logic [13:0] mag_a_r, mag_b_r;

    asf_mode_t mode;
    logic mag_cap, mag_on, mag_valid, ctrl_wr;
    logic [13:0] mag_val;
    logic [7:0] eff_addr;
    logic rd_out, pop, push, full, stop_full, thresh_flag, byp_now;
    asf_sample_t push_data, head;

    // ******************************************
    // magnitude unit
    // ******************************************
    asf_magnitude u_mag (
        .core_clk (core_clk),
        .resetn (resetn),
        .in_valid (sample_valid),
        .in_sample (sample_in),
        .mag_valid (mag_valid),
        .mag_r (mag_val)
    );

    // ******************************************
    // decode
    // ******************************************
    always_comb begin
        mode = asf_mode_t'(buf_ctrl_r[POS_MODE +: 3]);
        mag_cap = buf_ctrl_r[BIT_MAG_CAPTURE];
        // capture follows the routine only once it is running
        mag_on = embedded_function_control_r[BIT_MAG_ROUTINE];
        ctrl_wr = reg_wr && (reg_addr == OFS_BUF_CTRL);
        full = (count_r == ASF_FULL);
        byp_now = (mode == MODE_BYPASS) ||
                  (mode == MODE_BYP_TO_CONT && !trig_seen_r);
        stop_full = (mode == MODE_STOP_FULL) ||
                    (mode == MODE_CONT_TO_STOP && trig_seen_r);
    end

    // auto-increment address with wrap on the output window
    always_comb begin
        eff_addr = reg_addr;
        if (reg_burst && if_ctrl_r[BIT_ADDR_INC] &&
            last_addr_r >= OFS_OUT_FIRST && last_addr_r <= OFS_OUT_LAST) begin
            if (last_addr_r == OFS_OUT_LAST) begin
                eff_addr = OFS_OUT_FIRST;
            end else begin
                eff_addr = last_addr_r + 8'h01;
            end
        end
    end

    // ******************************************
    // push and pop
    // ******************************************
    always_comb begin
        rd_out = reg_rd && eff_addr == OFS_OUT_LAST;
        pop = rd_out && !byp_now && count_r != RST_COUNT;
        push = 1'b0;
        push_data = latest_r;
        if (!ctrl_wr && !byp_now) begin
            if (mag_cap) begin
                // row written on every third magnitude
                push = mag_valid && mag_on && mag_idx_r == 2'd2;
                push_data = '{x: mag_a_r, y: mag_b_r, z: mag_val};
            end else begin
                push = mag_valid;
            end
            if (stop_full && full && !pop) begin
                push = 1'b0;
            end
        end
    end

    // ******************************************
    // storage
    // ******************************************
    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wr_ptr_r] <= push_data;
        end
    end

    assign head = store[rd_ptr_r];

    // ******************************************
    // pointers and count
    // ******************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wr_ptr_r <= 8'h00;
            rd_ptr_r <= 8'h00;
            count_r <= RST_COUNT;
        end else if (byp_now || (ctrl_wr &&
                     reg_wdata[POS_MODE +: 3] == MODE_BYPASS)) begin
            // bypass holds the buffer empty
            wr_ptr_r <= 8'h00;
            rd_ptr_r <= 8'h00;
            count_r <= RST_COUNT;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 8'h01;
            end
            if (pop || (push && full)) begin
                // full push drops the oldest
                rd_ptr_r <= rd_ptr_r + 8'h01;
            end
            if (push && !pop && !full) begin
                count_r <= count_r + 9'h001;
            end else if (pop && !push) begin
                count_r <= count_r - 9'h001;
            end
        end
    end

    // overwrite of unread slot sets overrun; set beats clear
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            overrun_r <= 1'b0;
        end else if (push && full && !pop) begin
            overrun_r <= 1'b1;
        end else if (pop || byp_now) begin
            overrun_r <= 1'b0;
        end
    end

    // trigger latch; a new mode write rearms it
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            trig_seen_r <= 1'b0;
        end else if (ctrl_wr) begin
            trig_seen_r <= 1'b0;
        end else if (trigger_evt) begin
            trig_seen_r <= 1'b1;
        end
    end

    // ******************************************
    // latest sample and magnitude staging
    // ******************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            latest_r <= '0;
            mag_high_r <= RST_REG;
        end else begin
            if (sample_valid) begin
                latest_r <= sample_in;
            end
            if (mag_valid && mag_on) begin
                mag_high_r <= mag_val[13:6];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mag_idx_r <= 2'd0;
            mag_a_r <= 14'h0000;
            mag_b_r <= 14'h0000;
        end else if (ctrl_wr || !mag_cap || byp_now || !mag_on) begin
            mag_idx_r <= 2'd0;
        end else if (mag_valid && !push && stop_full && full) begin
            mag_idx_r <= mag_idx_r;
        end else if (mag_valid) begin
            // three magnitudes per row
            if (mag_idx_r == 2'd0) begin
                mag_a_r <= mag_val;
            end
            if (mag_idx_r == 2'd1) begin
                mag_b_r <= mag_val;
            end
            mag_idx_r <= (mag_idx_r == 2'd2) ? 2'd0 : mag_idx_r + 2'd1;
        end
    end

    // ******************************************
    // flags and interrupt pins
    // ******************************************
    always_comb begin
        thresh_flag = 1'b0;
        if (thresh_r != 8'h00) begin
            thresh_flag = count_r >= {1'b0, thresh_r};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_pin_a <= 1'b0;
            irq_pin_b <= 1'b0;
        end else begin
            // routing of threshold and overrun
            irq_pin_a <= (irq_a_r[BIT_THRESH_ROUTE] & thresh_flag) |
                         (irq_a_r[BIT_OVR_ROUTE] & overrun_r);
            irq_pin_b <= (irq_b_r[BIT_THRESH_ROUTE] & thresh_flag) |
                         (irq_b_r[BIT_OVR_ROUTE] & overrun_r);
        end
    end

    // ******************************************
    // register writes
    // ******************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            if_ctrl_r <= RST_REG;
            irq_a_r <= RST_REG;
            irq_b_r <= RST_REG;
            buf_ctrl_r <= RST_REG;
            thresh_r <= RST_REG;
            embedded_function_control_r <= RST_REG;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_IF_CTRL: if_ctrl_r <= reg_wdata;
                OFS_IRQ_A: irq_a_r <= reg_wdata;
                OFS_IRQ_B: irq_b_r <= reg_wdata;
                OFS_BUF_CTRL: buf_ctrl_r <= reg_wdata;
                OFS_THRESH: thresh_r <= reg_wdata;
                OFS_EMBEDDED_FUNCTION_CONTROL: embedded_function_control_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ******************************************
    // register reads
    // ******************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            last_addr_r <= 8'h00;
        end else if (reg_rd) begin
            last_addr_r <= eff_addr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= 8'h00;
            if (eff_addr >= OFS_OUT_FIRST && eff_addr <= OFS_OUT_LAST) begin
                // oldest set outside bypass, else latest
                reg_rdata <= out_byte(byp_now ? latest_r : head,
                                      3'(eff_addr - OFS_OUT_FIRST));
            end else begin
                case (eff_addr)
                    OFS_MAG_HIGH: reg_rdata <= mag_high_r;
                    OFS_IF_CTRL: reg_rdata <= if_ctrl_r;
                    OFS_IRQ_A: reg_rdata <= irq_a_r;
                    OFS_IRQ_B: reg_rdata <= irq_b_r;
                    OFS_BUF_CTRL: reg_rdata <= buf_ctrl_r;
                    OFS_THRESH: reg_rdata <= thresh_r;
                    OFS_EMBEDDED_FUNCTION_CONTROL: reg_rdata <= embedded_function_control_r;
                    OFS_SRC: begin
                        // status and count top bit
                        reg_rdata <= {thresh_flag, overrun_r,
                                      count_r == RST_COUNT, 4'h0,
                                      count_r[8]};
                    end
                    OFS_COUNT: reg_rdata <= count_r[7:0];
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

//--- asf_buffer_sva.sv
// assertions on the sample buffer register port and irq pins
`timescale 1ns/1ps
`default_nettype none
module asf_buffer_sva
    import asf_pkg::*;
#(
    parameter int DEPTH = ASF_DEPTH
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // samples and trigger
    input wire logic sample_valid,
    input wire asf_sample_t sample_in,
    input wire logic trigger_evt,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_burst,
    input wire logic [7:0] reg_rdata,
    // interrupt pins
    input wire logic irq_pin_a,
    input wire logic irq_pin_b
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ****
    // shadow copies of written registers
    // ****
    logic [7:0] thr_r, ra_r, rb_r, md_r;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            thr_r <= 8'h00;
            ra_r <= 8'h00;
            rb_r <= 8'h00;
            md_r <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == OFS_THRESH) thr_r <= reg_wdata;
            if (reg_addr == OFS_IRQ_A) ra_r <= reg_wdata;
            if (reg_addr == OFS_IRQ_B) rb_r <= reg_wdata;
            if (reg_addr == OFS_BUF_CTRL) md_r <= reg_wdata;
        end
    end
    // ****
    // properties
    // ****
    sequence s_rd(logic [7:0] a);
        reg_rd && !reg_burst && reg_addr == a;
    endsequence
    sequence s_byp;
        (md_r[7:5] == 3'h0)[*3];
    endsequence
    chk_route_a_off: assert property (
        (!ra_r[1] && !ra_r[3])[*3] |-> !irq_pin_a)
        else $error("irq pin a high while unrouted");
    chk_route_b_off: assert property (
        (!rb_r[1] && !rb_r[3])[*3] |-> !irq_pin_b)
        else $error("irq pin b high while unrouted");
    chk_thr_zero: assert property (
        (thr_r == 8'h00)[*3] ##0 s_rd(OFS_SRC) |=> !reg_rdata[7])
        else $error("threshold flag set with zero threshold");
    chk_full_flag: assert property (
        (thr_r != 8'h00)[*3] ##0 s_rd(OFS_SRC) ##1 reg_rdata[0]
        |-> reg_rdata[BIT_SRC_THRESH])
        else $error("full buffer without threshold flag");
    chk_empty_bits: assert property (
        s_rd(OFS_SRC) |=> !(reg_rdata[BIT_SRC_EMPTY] && reg_rdata[0]))
        else $error("empty and full reported together");
    chk_byp_src: assert property (
        s_byp ##0 s_rd(OFS_SRC) |=> reg_rdata[BIT_SRC_EMPTY]
        && !reg_rdata[0] && !reg_rdata[BIT_SRC_OVR])
        else $error("bypass buffer not empty");
    chk_byp_count: assert property (
        s_byp ##0 s_rd(OFS_COUNT) |=> reg_rdata == 8'h00)
        else $error("bypass count not zero");
    chk_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule
bind asf_buffer asf_buffer_sva #(.DEPTH(DEPTH)) u_chk (
    .core_clk(core_clk), .resetn(resetn),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .trigger_evt(trigger_evt), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_burst(reg_burst), .reg_rdata(reg_rdata),
    .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));
`default_nettype wire

//--- asf_host.sv
// host model driving register reads and writes
`timescale 1ns/1ps
`default_nettype none
module asf_host
(
    // clock
    input wire logic core_clk,
    // register port
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    output var logic reg_burst,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_burst = 1'h0;
    end
    // ****
    // bus cycles; released address and write data lines show inverted values, strobes and burst go low
    // ****
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input logic [7:0] a, input logic b,
                      output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_burst <= b;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        reg_burst <= 1'h0;
        reg_addr <= ~a;
        #1 v = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- tb_asf_buffer.sv
// self-checking bench for the sample buffer
`timescale 1ns/1ps
`default_nettype none
module tb_asf_buffer
    import asf_pkg::*;
;
    logic core_clk, resetn, sample_valid, trigger_evt;
    asf_sample_t sample_in;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, reg_burst, irq_pin_a, irq_pin_b;
    int mismatches, n_tests;
    asf_buffer dut (.core_clk(core_clk), .resetn(resetn),
        .sample_valid(sample_valid), .sample_in(sample_in),
        .trigger_evt(trigger_evt), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_burst(reg_burst), .reg_rdata(reg_rdata),
        .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));
    asf_host host (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_burst(reg_burst), .reg_rdata(reg_rdata));
    // ****
    // helpers
    // ****
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %0t: got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] lo(input logic [13:0] v);
        return {v[5:0], 2'h0};
    endfunction
    function automatic logic [7:0] hi(input logic [13:0] v);
        return v[13:6];
    endfunction
    function automatic logic [7:0] eb(input int k);
        logic [13:0] v;
        v = 14'h0100 + 14'(k / 6) + 14'((k % 6) / 2);
        return k[0] ? hi(v) : lo(v);
    endfunction
    task automatic rdc(input logic [7:0] a, e, m = 8'hff);
        host.rd(a, 1'h0, d);
        chk(d & m, e);
    endtask
    task automatic cnt(input logic [8:0] e);
        rdc(OFS_COUNT, e[7:0]);
        rdc(OFS_SRC, {7'h0, e[8]}, 8'h01);
    endtask
    task automatic push(input logic [13:0] v, input logic s);
        @(posedge core_clk);
        sample_valid <= 1'h1;
        sample_in <= '{v, s ? v + 14'h1 : 14'h0, s ? v + 14'h2 : 14'h0};
        @(posedge core_clk);
        sample_valid <= 1'h0;
        sample_in <= ~sample_in;
        @(posedge core_clk);
    endtask
    task automatic fill(input logic [13:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            push(b + i[13:0], 1'h1);
        end
    endtask
    task automatic trig;
        @(posedge core_clk);
        trigger_evt <= 1'h1;
        @(posedge core_clk);
        trigger_evt <= 1'h0;
    endtask
    task automatic pin(input logic a, input logic b);
        repeat (3) @(posedge core_clk);
        #1 chk({7'h0, irq_pin_a}, {7'h0, a});
        chk({7'h0, irq_pin_b}, {7'h0, b});
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_regs;
        rdc(OFS_BUF_CTRL, 8'h00);
        rdc(OFS_SRC, 8'h20, 8'he1);
        host.wr(OFS_THRESH, 8'h5a);
        rdc(OFS_THRESH, 8'h5a);
        host.wr(OFS_SRC, 8'hff);
        host.wr(OFS_COUNT, 8'h12);
        cnt(9'h000);
        rdc(8'h00, 8'h00);
    endtask
    task automatic t_byp;
        fill(14'h1abc, 2);
        cnt(9'h000);
        rdc(OFS_OUT_FIRST, lo(14'h1abd));
        rdc(8'h29, hi(14'h1abd));
    endtask
    task automatic t_stop;
        host.wr(OFS_BUF_CTRL, 8'h20);
        host.wr(OFS_THRESH, 8'h02);
        host.wr(OFS_IF_CTRL, 8'h04);
        fill(14'h0100, 257);
        cnt(9'h100);
        rdc(OFS_SRC, 8'h80, 8'hc0);
        rdc(OFS_OUT_FIRST, eb(0));
        for (int k = 1; k < 7; k++) begin
            host.rd(8'h00, 1'h1, d);
            chk(d, eb(k));
        end
        cnt(9'h0ff);
        host.wr(OFS_BUF_CTRL, 8'h00);
        cnt(9'h000);
        host.wr(OFS_BUF_CTRL, 8'h20);
        push(14'h0005, 1'h1);
        cnt(9'h001);
        host.wr(OFS_IF_CTRL, 8'h00);
    endtask
    task automatic t_cont;
        host.wr(OFS_BUF_CTRL, 8'h00);
        host.wr(OFS_BUF_CTRL, 8'hc0);
        host.wr(OFS_THRESH, 8'h10);
        host.wr(OFS_IRQ_A, 8'h02);
        fill(14'h0200, 258);
        cnt(9'h100);
        rdc(OFS_SRC, 8'hc0, 8'hc0);
        rdc(OFS_OUT_FIRST, lo(14'h0202));
        rdc(8'h29, hi(14'h0202));
        pin(1'h1, 1'h0);
        host.wr(OFS_IRQ_B, 8'h02);
        pin(1'h1, 1'h1);
        host.wr(OFS_THRESH, 8'h00);
        pin(1'h0, 1'h0);
        host.wr(OFS_IRQ_A, 8'h08);
        pin(1'h1, 1'h0);
    endtask
    task automatic t_trig;
        host.wr(OFS_BUF_CTRL, 8'h00);
        host.wr(OFS_BUF_CTRL, 8'h80);
        fill(14'h0300, 2);
        cnt(9'h000);
        trig;
        fill(14'h0302, 2);
        cnt(9'h002);
        rdc(OFS_OUT_FIRST, lo(14'h0302));
        host.wr(OFS_THRESH, 8'h02);
        rdc(OFS_SRC, 8'h80, 8'h80);
        host.wr(OFS_THRESH, 8'h03);
        rdc(OFS_SRC, 8'h00, 8'h80);
        host.wr(OFS_BUF_CTRL, 8'h00);
        host.wr(OFS_BUF_CTRL, 8'h60);
        fill(14'h0400, 257);
        trig;
        push(14'h07ff, 1'h1);
        cnt(9'h100);
        rdc(OFS_OUT_FIRST, lo(14'h0401));
    endtask
    task automatic t_mag;
        host.wr(OFS_BUF_CTRL, 8'h00);
        host.wr(OFS_EMBEDDED_FUNCTION_CONTROL, 8'h20);
        host.wr(OFS_BUF_CTRL, 8'hc8);
        push(14'h0123, 1'h0);
        push(14'h02a5, 1'h0);
        push(14'h031f, 1'h0);
        cnt(9'h001);
        rdc(OFS_MAG_HIGH, hi(14'h031f));
        rdc(OFS_OUT_FIRST, lo(14'h0123));
        rdc(8'h2a, lo(14'h02a5));
        rdc(OFS_OUT_LAST, hi(14'h031f));
        cnt(9'h000);
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****
    // clock, reset, sequence and watchdog
    // ****
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        resetn = 1'h0;
        sample_valid = 1'h0;
        trigger_evt = 1'h0;
        sample_in = '0;
        mismatches = 0;
        n_tests = 0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'h1;
        t_regs;
        t_byp;
        t_stop;
        t_cont;
        t_trig;
        t_mag;
        report_and_stop;
    end
    initial begin
        #200000;
        mismatches++;
        report_and_stop;
    end
endmodule
`default_nettype wire
